// file: hw/seep_device.sv
// three-wire serial eeprom device: 64 words of 16 bits with self-timed programming
`timescale 1ns/1ps
// What this block does
// - sixty-four words of sixteen bits, six-bit address
// - start bit, opcode, address, then data
// - static: state held while serial clock stops
// - read loads word, sends dummy zero first
// - read output changes on serial clock rise
// - only read returns data bits
// - write is opcode 01, address, sixteen bits
// - erase is opcode 11 plus address
// - 00 11xxxx sets write-enable latch
// - 00 00xxxx clears write-enable latch
// - 00 01xxxx plus data fills all words
// - 00 10xxxx clears whole array
// - last sixteen shifted bits are the data
// - program only with latch set, supply ok
// - word write erases then programs, one cycle
// - chip select high shows busy/ready after start
// - latch clear at power-up
// - output high impedance while chip select low
// - read keeps streaming following words
// - read address increments, wraps to zero
// - chip select fall starts programming cycle
// - status zero while busy, one when done
// - erase and clear-all set bits to one
module seep_device #(
  parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // serial pins from the host
  input wire seep_pkg::seep_pins_s pins_in,
  // supply above lockout level
  input wire logic supply_lockout_level_ok_in,
  // serial output pin, split into level and enable
  output logic serial_out_out,
  output logic serial_out_oe_out
);
  import seep_pkg::*;

  seep_regs_s q;
  seep_regs_s d;
  logic sk_rise;
  logic cs_fall;
  logic cs;
  logic di;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // next word address with wrap from top to zero
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
    return a + 6'h01;
  endfunction : next_addr

  // pin events, all sampled in the system clock
  assign cs = pins_in.chip_select;
  assign di = pins_in.serial_in;
  assign sk_rise = pins_in.serial_clock & ~q.sk_prev;
  assign cs_fall = ~cs & q.cs_prev;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // instruction decode, shifting, programming timer
  always_comb begin
    d = q;
    d.sk_prev = pins_in.serial_clock;
    d.cs_prev = cs;
    case (q.st)
      ST_BUSY: begin
        if (q.timer == '0) begin
          // apply the operation at the end of the self-timed cycle
          case (q.op)
            OP_WORD: d.mem[q.word_address] = q.data_word;
            OP_ERASE: d.mem[q.word_address] = ERASED_WORD;
            OP_FILL: begin
              for (int i = 0; i < WORDS; i++) begin
                d.mem[i] = q.data_word;
              end
            end
            default: begin
              for (int i = 0; i < WORDS; i++) begin
                d.mem[i] = ERASED_WORD;
              end
            end
          endcase
          d.st = ST_IDLE;
        end else begin
          d.timer = q.timer - 22'h000001;
        end
      end
      default: begin
        if (!cs) begin
          d.st = ST_IDLE;
          if (cs_fall && (q.st == ST_DATA || q.st == ST_ARMED)) begin
            if (q.wel && supply_lockout_level_ok_in) begin
              d.st = ST_BUSY;
              d.timer = TIMER_W'(PROG_CYCLES - 1);
              d.status = 1'b1;
            end
          end
        end else if (sk_rise) begin
          case (q.st)
            ST_IDLE: begin
              if (di) begin
                d.st = ST_CMD;
                d.cnt = '0;
                d.status = 1'b0;
              end
            end
            ST_CMD: begin
              d.cmd = {q.cmd[CMD_W-2:0], di};
              d.cnt = q.cnt + 4'h1;
              if (q.cnt == LAST_CMD_BIT) begin
                d.word_address = d.cmd[ADDR_W-1:0];
                d.cnt = '0;
                case (d.cmd[CMD_W-1:CMD_W-2])
                  OPC_READ: begin
                    d.st = ST_READ;
                    d.data_word = q.mem[d.cmd[ADDR_W-1:0]];
                    d.out_bit = 1'b0;
                  end
                  OPC_WRITE: begin
                    d.st = ST_DATA;
                    d.op = OP_WORD;
                  end
                  OPC_ERASE: begin
                    d.st = ST_ARMED;
                    d.op = OP_ERASE;
                  end
                  default: begin
                    case (d.cmd[ADDR_W-1:ADDR_W-2])
                      SUB_ENABLE: begin
                        d.wel = 1'b1;
                        d.st = ST_SKIP;
                      end
                      SUB_DISABLE: begin
                        d.wel = 1'b0;
                        d.st = ST_SKIP;
                      end
                      SUB_FILL: begin
                        d.st = ST_DATA;
                        d.op = OP_FILL;
                      end
                      default: begin
                        d.st = ST_ARMED;
                        d.op = OP_CLEAR;
                      end
                    endcase
                  end
                endcase
              end
            end
            ST_DATA: begin
              d.data_word = {q.data_word[WORD_W-2:0], di};
            end
            ST_READ: begin
              d.out_bit = q.data_word[WORD_W-1];
              d.data_word = {q.data_word[WORD_W-2:0], 1'b0};
              d.cnt = q.cnt + 4'h1;
              if (q.cnt == LAST_DATA_BIT) begin
                d.word_address = next_addr(q.word_address);
                d.data_word = q.mem[next_addr(q.word_address)];
                d.cnt = '0;
              end
            end
            default: begin
              d.st = q.st;
            end
          endcase
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // array powers up erased, latch cleared
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.mem <= '1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output

  // data only during read, otherwise busy/ready once programming started
  assign serial_out_oe_out = cs & ((q.st == ST_READ) | q.status);
  assign serial_out_out = (q.st == ST_READ) ? q.out_bit : (q.st != ST_BUSY);

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_hiz_when_deselected;
    @(posedge clock_in) disable iff (!rst_b_in)
      !cs |-> !serial_out_oe_out;
  endproperty
  a_hiz_when_deselected: assert property (p_hiz_when_deselected) else $error("output driven while deselected");

  property p_dummy_zero;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_READ) && ($past(q.st) == ST_CMD) && cs |-> serial_out_oe_out && !serial_out_out;
  endproperty
  a_dummy_zero: assert property (p_dummy_zero) else $error("read did not start with dummy zero");

  property p_read_changes_on_rise;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_READ) && $past(q.st == ST_READ) && !$past(sk_rise) |-> $stable(q.out_bit);
  endproperty
  a_read_changes_on_rise: assert property (p_read_changes_on_rise) else $error("read output moved without clock rise");

  property p_only_read_drives_data;
    @(posedge clock_in) disable iff (!rst_b_in)
      serial_out_oe_out && (q.st != ST_READ) |-> q.status && (serial_out_out == (q.st != ST_BUSY));
  endproperty
  a_only_read_drives_data: assert property (p_only_read_drives_data) else $error("data driven outside read");

  property p_program_needs_latch;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_BUSY) && ($past(q.st) != ST_BUSY) |-> $past(q.wel) && $past(supply_lockout_level_ok_in);
  endproperty
  a_program_needs_latch: assert property (p_program_needs_latch) else $error("programming started while locked");

  property p_timer_bound;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_BUSY) |-> (int'(q.timer) < PROG_CYCLES);
  endproperty
  a_timer_bound: assert property (p_timer_bound) else $error("programming timer beyond limit");

  property p_busy_status;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_BUSY) && cs |-> serial_out_oe_out && !serial_out_out;
  endproperty
  a_busy_status: assert property (p_busy_status) else $error("busy not shown as zero");

  property p_erase_ones;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_BUSY) && (q.timer == '0) && (q.op == OP_ERASE) |=> (q.mem[q.word_address] == ERASED_WORD);
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erased word not all ones");

  property p_read_wraps;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_READ) && cs && sk_rise && (q.cnt == LAST_DATA_BIT)
        |=> (q.word_address == next_addr($past(q.word_address))) && (q.cnt == '0);
  endproperty
  a_read_wraps: assert property (p_read_wraps) else $error("read address did not advance");

  property p_start_on_cs_fall;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_BUSY) && ($past(q.st) != ST_BUSY) |-> $past(cs_fall);
  endproperty
  a_start_on_cs_fall: assert property (p_start_on_cs_fall) else $error("programming began without chip select fall");

  property p_latch_by_instr;
    @(posedge clock_in) disable iff (!rst_b_in)
      $changed(q.wel) |-> $past(q.st == ST_CMD) && $past(sk_rise && cs) && $past(q.cnt == LAST_CMD_BIT);
  endproperty
  a_latch_by_instr: assert property (p_latch_by_instr) else $error("latch moved outside an instruction");

  property p_refused_start;
    @(posedge clock_in) disable iff (!rst_b_in)
      cs_fall && ((q.st == ST_DATA) || (q.st == ST_ARMED)) && !(q.wel && supply_lockout_level_ok_in)
        |=> (q.st == ST_IDLE) && !q.status;
  endproperty
  a_refused_start: assert property (p_refused_start) else $error("locked programming was started");

  property p_mem_only_at_end;
    @(posedge clock_in) disable iff (!rst_b_in)
      !$stable(q.mem) |-> $past(q.st == ST_BUSY) && $past(q.timer == '0);
  endproperty
  a_mem_only_at_end: assert property (p_mem_only_at_end) else $error("array changed outside programming");

  property p_word_write;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_BUSY) && (q.timer == '0) && (q.op == OP_WORD) |=> (q.mem[q.word_address] == $past(q.data_word));
  endproperty
  a_word_write: assert property (p_word_write) else $error("word write did not land");

  property p_fill_all;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_BUSY) && (q.timer == '0) && (q.op == OP_FILL)
        |=> (q.mem[0] == $past(q.data_word)) && (q.mem[WORDS-1] == $past(q.data_word));
  endproperty
  a_fill_all: assert property (p_fill_all) else $error("fill did not reach the whole array");

  property p_clear_all;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_BUSY) && (q.timer == '0) && (q.op == OP_CLEAR)
        |=> (q.mem[0] == ERASED_WORD) && (q.mem[WORDS-1] == ERASED_WORD);
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear did not erase the whole array");

  property p_ready_after_busy;
    @(posedge clock_in) disable iff (!rst_b_in)
      (q.st == ST_BUSY) && (q.timer == '0) |=> (q.st == ST_IDLE) && q.status;
  endproperty
  a_ready_after_busy: assert property (p_ready_after_busy) else $error("ready not shown after programming");
endmodule : seep_device

// file: hw/seep_pkg.sv
// package of constants, types and state layout for the serial eeprom device
package seep_pkg;
  // array shape
  localparam int WORDS = 64;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 6;
  localparam int CMD_W = 8;
  localparam int CNT_W = 4;
  // opcodes and sub-codes of the 00 group
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  // erased value and last bit indices
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
  localparam logic [CNT_W-1:0] LAST_DATA_BIT = 4'hf;
  localparam logic [CNT_W-1:0] LAST_CMD_BIT = 4'h7;
  // self-timed programming cycle
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint PROG_TIME_NS = 10_000_000;
  localparam int PROG_CYCLES = int'((PROG_TIME_NS * 1000) / CLK_PERIOD_PS);
  localparam int TIMER_W = 22;
  // controller states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_DATA,
    ST_ARMED,
    ST_READ,
    ST_SKIP,
    ST_BUSY
  } seep_state_e;
  // programming operations
  typedef enum logic [1:0] {
    OP_WORD,
    OP_ERASE,
    OP_FILL,
    OP_CLEAR
  } seep_op_e;
  // serial pins from the host
  typedef struct packed {
    logic chip_select;
    logic serial_clock;
    logic serial_in;
  } seep_pins_s;
  // whole state of the device
  typedef struct packed {
    seep_state_e st;
    seep_op_e op;
    logic sk_prev;
    logic cs_prev;
    logic [CNT_W-1:0] cnt;
    logic [CMD_W-1:0] cmd;
    logic [ADDR_W-1:0] word_address;
    logic [WORD_W-1:0] data_word;
    logic out_bit;
    logic wel;
    logic status;
    logic [TIMER_W-1:0] timer;
    logic [WORDS-1:0][WORD_W-1:0] mem;
  } seep_regs_s;
endpackage : seep_pkg

// file: test/seep_host.sv
// host-side model: drives chip select, serial clock and serial input, samples the output pin
`timescale 1ns/1ps
module seep_host (
  // clock
  input wire logic clock_in,
  // output pin of the device
  input wire logic serial_out_in,
  input wire logic serial_out_oe_in,
  // serial pins to the device
  output seep_pkg::seep_pins_s pins_out
);
  import seep_pkg::*;
  logic last_seen;
  ////////////////////////////////////////////////////////////////////////////////
  // idle pins at time zero: serial clock stands still low outside frames
  initial begin
    pins_out = '0;
    last_seen = 1'b0;
  end
  // lets n clock edges pass, then changes land just after the edge
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_n
  // one serial clock period: data set while low, held through the rise
  task automatic clk_bit(input logic b, output logic seen);
    pins_out.serial_in = b;
    pins_out.serial_clock = 1'b0;
    wait_n(3);
    pins_out.serial_clock = 1'b1;
    wait_n(3);
    // a released pin is seen as the inverse of its last level
    seen = serial_out_oe_in ? serial_out_in : ~last_seen;
    last_seen = seen;
  endtask : clk_bit
  // shifts n bits, most significant first
  task automatic send(input int n, input logic [31:0] v);
    logic s;
    for (int i = n - 1; i >= 0; i--) clk_bit(v[i], s);
  endtask : send
  // shifts n bits in from the output pin, most significant first
  task automatic recv(input int n, output logic [31:0] v);
    logic s;
    v = '0;
    for (int i = n - 1; i >= 0; i--) begin
      clk_bit(1'b0, s);
      v[i] = s;
    end
  endtask : recv
  // moves chip select with the serial clock low, held two edges
  task automatic select(input logic cs);
    pins_out.chip_select = cs;
    pins_out.serial_clock = 1'b0;
    wait_n(2);
  endtask : select
endmodule : seep_host

// file: test/tb_top.sv
// self-checking bench for the serial eeprom device
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; $display("Error %s exp %h seen %h", nm, ex, got); end end
module tb_top;
  import seep_pkg::*;
  localparam int PROG_N = 20;
  logic clk;
  logic rst_b;
  logic sup_ok;
  logic dout;
  logic doe;
  seep_pins_s pins;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  integer seed = 32'h5a23;
  logic [WORD_W-1:0] model [WORDS];
  logic [ADDR_W-1:0] a;
  logic [31:0] d;
  logic [31:0] got;
  seep_device #(.PROG_CYCLES(PROG_N)) u_dut (.clock_in(clk), .rst_b_in(rst_b), .pins_in(pins),
    .supply_lockout_level_ok_in(sup_ok), .serial_out_out(dout), .serial_out_oe_out(doe));
  seep_host u_host (.clock_in(clk), .serial_out_in(dout), .serial_out_oe_in(doe), .pins_out(pins));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 60000) begin
      err_total++;
      summarize();
    end
  end
  // data word kept from an overlong data field: the final sixteen bits
  function automatic logic [WORD_W-1:0] kept_word(input logic [31:0] v);
    return v[WORD_W-1:0];
  endfunction : kept_word
  // one framed instruction; no data bits come back for it
  task automatic instr(input logic [1:0] opc, input logic [5:0] adr, input int nd, input logic [31:0] v);
    u_host.select(1'b1);
    u_host.send(9, {1'b1, opc, adr});
    if (nd > 0) u_host.send(nd, v);
    `CHK("no_data_oe", 1'b0, doe)
    u_host.select(1'b0);
  endtask : instr
  // status check after chip select fall, bounded wait for ready
  task automatic prog_wait(input logic busy);
    int k;
    k = 0;
    u_host.select(1'b1);
    `CHK("status_oe", busy, doe)
    if (busy) begin
      `CHK("busy_level", 1'b0, dout)
      while (dout !== 1'b1 && k < PROG_N + 4) begin
        u_host.wait_n(1);
        k++;
      end
      `CHK("ready_level", 1'b1, dout)
    end
    u_host.select(1'b0);
  endtask : prog_wait
  // reads n consecutive words and compares them with the model
  task automatic read_chk(input logic [5:0] adr, input int n);
    logic [31:0] v;
    logic [5:0] p;
    p = adr;
    u_host.select(1'b1);
    u_host.send(9, {1'b1, OPC_READ, adr});
    `CHK("dummy_bit", 1'b0, dout)
    for (int i = 0; i < n; i++) begin
      u_host.recv(16, v);
      `CHK("read_word", model[p], v[15:0])
      p = p + 6'h1;
    end
    u_host.select(1'b0);
    `CHK("oe_idle", 1'b0, doe)
  endtask : read_chk
  // final verdict, ends the run
  task automatic summarize();
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_b = 1'b0;
    sup_ok = 1'b1;
    for (int i = 0; i < WORDS; i++) model[i] = ERASED_WORD;
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    u_host.wait_n(2);
    `CHK("oe_reset", 1'b0, doe)
    // write before any enable is refused
    a = 6'($random(seed));
    d = $random(seed);
    instr(OPC_WRITE, a, 16, d);
    prog_wait(1'b0);
    read_chk(a, 1);
    instr(OPC_EXT, {SUB_ENABLE, 4'($random(seed))}, 0, d);
    // word writes with twenty data bits, top and bottom addresses among them
    for (int i = 0; i < 4; i++) begin
      a = (i == 1) ? 6'h3f : (i == 2) ? 6'h00 : 6'($random(seed));
      d = $random(seed);
      instr(OPC_WRITE, a, 20, d);
      model[a] = kept_word(d);
      prog_wait(1'b1);
      read_chk(a, 1);
    end
    // leading zeros, then a long clock pause mid-instruction on the last written word
    u_host.select(1'b1);
    u_host.send(3, 32'h0);
    u_host.send(5, {1'b1, OPC_READ, a[5:4]});
    u_host.wait_n(50);
    u_host.send(4, {28'h0, a[3:0]});
    `CHK("paused_dummy", 1'b0, dout)
    u_host.recv(17, got);
    `CHK("paused_read", {model[a], model[a + 6'h1][15]}, got[16:0])
    u_host.select(1'b0);
    read_chk(6'h3f, 3);
    instr(OPC_ERASE, 6'h3f, 0, d);
    model[63] = ERASED_WORD;
    prog_wait(1'b1);
    read_chk(6'h3e, 2);
    // fill refused with supply low
    sup_ok = 1'b0;
    instr(OPC_EXT, {SUB_FILL, 4'($random(seed))}, 16, d);
    prog_wait(1'b0);
    sup_ok = 1'b1;
    d = $random(seed);
    instr(OPC_EXT, {SUB_FILL, 4'($random(seed))}, 16, d);
    for (int i = 0; i < WORDS; i++) model[i] = kept_word(d);
    prog_wait(1'b1);
    read_chk(6'h3f, 2);
    instr(OPC_EXT, {SUB_CLEAR, 4'($random(seed))}, 0, d);
    for (int i = 0; i < WORDS; i++) model[i] = ERASED_WORD;
    prog_wait(1'b1);
    read_chk(6'h10, 1);
    // disable, then a write is refused but reads still work
    instr(OPC_EXT, {SUB_DISABLE, 4'($random(seed))}, 0, d);
    a = 6'($random(seed));
    instr(OPC_WRITE, a, 16, d);
    prog_wait(1'b0);
    read_chk(a, 1);
    summarize();
  end
endmodule : tb_top
